// ---- dual_port_pin_mux_io.sv ----
// dual_port_pin_mux_io: 8-bit port A and 3-bit port B with alternate functions
// assumes: avalon-mm slave on clk_in, peripherals hand in their alternate values
// assumes: mode and standby inputs stay steady for a cycle around any access
// assumes: pin inputs are already synchronous; no filtering is done here
// limitation: bit 6 of the port A latch is stored but never read back
// hazard: a mode change reaches the pins in the same cycle, with no settling
//
// Behaviour
// - port A direction bit 1 drives pin
// - direction registers read back all ones
// - modes 1-2 hold pin 6 direction at 1
// - port A direction resets 40h or 00h
// - direction kept through software standby
// - port A read: latch or pin by direction
// - port A bit 6 reads pin only
// - port A latch clears, kept in standby
// - pin 7 wait input in modes 1-2 unless not used
// - pin 6 outputs system clock per mode
// - pins 5-3 drive bus strobes in modes 1-2
// - pins 2-1 feed irq 0 and 1
// - pin 0 feeds irq 2 and adc trigger
// - port B direction has three bits, F8h
// - port B bits 7-3 read as one
// - port B latch resets F8h, kept in standby
// - port B read: latch or pin by direction
// - software standby resets serial, pins revert
// - pin B2 serial clock in or out
// - pin B1 receive data while enabled
// - pin B0 transmit data while enabled
`timescale 1ns/1ps
module dual_port_pin_mux_io
	import port_mux_pkg::*;
(
	input  wire logic        clk_in,
	input  wire logic        rst_in,
	input  wire logic        hw_standby_in,
	input  wire logic        sw_standby_in,
	input  wire logic [1:0]  op_mode_in,
	// avalon-mm slave
	input  wire logic [17:0] avs_address_in,
	input  wire logic        avs_read_in,
	input  wire logic        avs_write_in,
	input  wire logic [31:0] avs_writedata_in,
	input  wire logic [3:0]  avs_byteenable_in,
	output logic [31:0]      avs_readdata_out,
	output logic             avs_waitrequest_out,
	output logic [1:0]       avs_response_out,
	// port A pins
	input  wire logic [7:0]  port_a_pin_in,
	output logic [7:0]       port_a_pin_out,
	output logic [7:0]       port_a_pin_oe_out,
	// port B pins
	input  wire logic [2:0]  port_b_pin_in,
	output logic [2:0]       port_b_pin_out,
	output logic [2:0]       port_b_pin_oe_out,
	// alternate functions of port A
	input  wire logic        sys_clock_in,
	input  wire logic        address_strobe_n_in,
	input  wire logic        write_strobe_n_in,
	input  wire logic        read_strobe_n_in,
	input  wire logic        wait_select_high_in,
	input  wire logic        wait_select_low_in,
	input  wire logic        ext_irq0_enable_in,
	input  wire logic        ext_irq1_enable_in,
	input  wire logic        ext_irq2_enable_in,
	input  wire logic        adc_trigger_enable_in,
	output logic             bus_wait_n_out,
	output logic [2:0]       ext_irq_n_out,
	output logic             adc_external_trigger_n_out,
	// alternate functions of port B
	input  wire logic        serial_sync_mode_in,
	input  wire logic        clock_enable_low_in,
	input  wire logic        clock_enable_high_in,
	input  wire logic        receive_enable_in,
	input  wire logic        transmit_enable_in,
	input  wire logic        serial_clock_in,
	input  wire logic        serial_txd_in,
	output logic             serial_clock_out,
	output logic             serial_rxd_out,
	output logic             serial_reset_out
);

	//------------------------------------------------------------
	// mode decode and bus decode
	//------------------------------------------------------------
	logic [7:0]  port_a_dir_ff;
	logic [7:0]  port_a_latch_ff;
	logic [2:0]  port_b_dir_ff;
	logic [2:0]  port_b_latch_ff;
	logic [31:0] avs_readdata_ff;
	logic        rd_done_ff;
	logic        init_req;
	logic        expanded;
	logic [15:0] reg_idx;
	logic        aligned;
	logic        wr_lane0;
	logic [7:0]  wdata;
	logic [7:0]  port_a_rd;
	logic [2:0]  port_b_rd;
	logic [7:0]  a_alt_drive;
	logic [7:0]  a_alt_input;
	logic [7:0]  a_alt_val;
	logic [2:0]  b_alt_drive;
	logic [2:0]  b_alt_input;
	logic [2:0]  b_alt_val;
	logic        wait_used;
	logic        serial_live;
	logic [7:0]  nxt_port_a_dir;
	logic [31:0] nxt_readdata;
	logic        sel_a_dir;
	logic        sel_a_data;
	logic        sel_b_dir;
	logic        sel_b_data;
	logic        wr_a_dir;
	logic        wr_a_data;
	logic        wr_b_dir;
	logic        wr_b_data;

	function automatic logic hit(input logic [15:0] idx, input logic [15:0] target);
		hit = aligned && (idx == target);
	endfunction

	// reset and hardware standby both initialise the registers
	assign init_req = rst_in | hw_standby_in;
	// reserved mode 0 counts as single chip, so no strobes ever appear
	assign expanded = (op_mode_in == mode_exp_rom_off) || (op_mode_in == mode_exp_rom_on);
	assign reg_idx  = avs_address_in[17:2];
	assign aligned  = (avs_address_in[1:0] == 2'b00);
	assign wr_lane0 = avs_write_in & avs_byteenable_in[0];
	assign wdata    = avs_writedata_in[7:0];

	// misaligned or unmapped addresses select nothing: writes drop, reads see zero
	assign sel_a_dir  = hit(reg_idx, port_a_direction_idx);
	assign sel_a_data = hit(reg_idx, port_a_data_latch_idx);
	assign sel_b_dir  = hit(reg_idx, port_b_direction_idx);
	assign sel_b_data = hit(reg_idx, port_b_data_latch_idx);
	// only byte lane 0 carries register data
	assign wr_a_dir   = wr_lane0 & sel_a_dir;
	assign wr_a_data  = wr_lane0 & sel_a_data;
	assign wr_b_dir   = wr_lane0 & sel_b_dir;
	assign wr_b_data  = wr_lane0 & sel_b_data;

	//------------------------------------------------------------
	// registers
	//------------------------------------------------------------
	always_comb begin
		nxt_port_a_dir = wdata;
		if (expanded) begin
			nxt_port_a_dir[clock_pin_bit] = 1'b1;
		end
	end

	// software standby changes nothing here, so contents persist
	always_ff @(posedge clk_in) begin
		if (init_req) begin
			port_a_dir_ff <= expanded ? port_a_dir_rst_expanded : port_a_dir_rst_single;
		end else if (wr_a_dir) begin
			port_a_dir_ff <= nxt_port_a_dir;
		end else if (expanded) begin
			port_a_dir_ff[clock_pin_bit] <= 1'b1;
		end
	end

	// bit 6 is written like the others, but reads always take the pin
	always_ff @(posedge clk_in) begin
		if (init_req) begin
			port_a_latch_ff <= port_a_data_rst;
		end else if (wr_a_data) begin
			port_a_latch_ff <= wdata;
		end
	end

	// port B keeps bits 2-0 only; the fixed ones are rebuilt on read
	always_ff @(posedge clk_in) begin
		if (init_req) begin
			port_b_dir_ff <= port_b_dir_rst[2:0];
		end else if (wr_b_dir) begin
			port_b_dir_ff <= wdata[2:0];
		end
	end

	always_ff @(posedge clk_in) begin
		if (init_req) begin
			port_b_latch_ff <= port_b_data_rst[2:0];
		end else if (wr_b_data) begin
			port_b_latch_ff <= wdata[2:0];
		end
	end

	//------------------------------------------------------------
	// avalon read path
	//------------------------------------------------------------
	// one wait cycle on reads lets the readdata flop settle; writes never wait
	always_comb begin
		nxt_readdata = 32'h0000_0000;
		if (sel_a_dir || sel_b_dir) begin
			nxt_readdata[7:0] = wo_read_value;
		end else if (sel_a_data) begin
			nxt_readdata[7:0] = port_a_rd;
		end else if (sel_b_data) begin
			nxt_readdata[7:0] = port_b_fixed_mask | {5'h00, port_b_rd};
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			rd_done_ff      <= 1'b0;
			avs_readdata_ff <= 32'h0000_0000;
		end else begin
			rd_done_ff <= avs_read_in & ~rd_done_ff;
			if (avs_read_in && !rd_done_ff) begin
				avs_readdata_ff <= nxt_readdata;
			end
		end
	end

	// readdata holds until the next read, so a slow master still sees it
	// response is always okay: nothing on this bus can fail
	assign avs_readdata_out    = avs_readdata_ff;
	assign avs_waitrequest_out = avs_read_in & ~rd_done_ff;
	assign avs_response_out    = 2'b00;

	//------------------------------------------------------------
	// port A alternate functions
	//------------------------------------------------------------
	// pin 7: wait input only while the wait controller listens to it
	// pin 6: clock out; its direction bit cannot drop in expanded modes
	// pins 5-3: strobes ignore the direction bits in expanded modes
	// pins 2-0: plain port; interrupt and trigger feeds only watch the pin
	logic       clock_pin_drive;
	logic [2:0] strobe_drive;
	logic [2:0] strobe_val;

	// a disabled feed rests high so nothing downstream sees a request
	function automatic logic gated_pin(input logic en, input logic lvl);
		gated_pin = en ? lvl : 1'b1;
	endfunction

	assign wait_used = expanded &&
		({wait_select_high_in, wait_select_low_in} != wait_not_used);
	// clock leaves through the latch-free path whenever its direction is 1
	assign clock_pin_drive = expanded | port_a_dir_ff[clock_pin_bit];
	assign strobe_drive    = {3{expanded}};
	assign strobe_val      = {address_strobe_n_in, write_strobe_n_in, read_strobe_n_in};

	always_comb begin
		a_alt_drive = 8'h00;
		a_alt_input = 8'h00;
		a_alt_val   = 8'h00;
		a_alt_input[wait_pin_bit]  = wait_used;
		a_alt_drive[clock_pin_bit] = clock_pin_drive;
		a_alt_val[clock_pin_bit]   = sys_clock_in;
		a_alt_drive[5:3]           = strobe_drive;
		a_alt_val[5:3]             = strobe_val;
	end

	assign bus_wait_n_out   = gated_pin(wait_used, port_a_pin_in[wait_pin_bit]);
	assign ext_irq_n_out[0] = gated_pin(ext_irq0_enable_in, port_a_pin_in[2]);
	assign ext_irq_n_out[1] = gated_pin(ext_irq1_enable_in, port_a_pin_in[1]);
	assign ext_irq_n_out[2] = gated_pin(ext_irq2_enable_in, port_a_pin_in[0]);
	assign adc_external_trigger_n_out =
		gated_pin(adc_trigger_enable_in, port_a_pin_in[0]);

	//------------------------------------------------------------
	// port B alternate functions
	//------------------------------------------------------------
	// standby resets the serial unit; pins then fall back to the port
	assign serial_live      = ~sw_standby_in & ~init_req;
	assign serial_reset_out = ~serial_live;

	logic sclk_is_input;
	logic sclk_is_output;
	logic rxd_is_input;
	logic txd_is_output;

	// an external clock wins over the internal one when both enables are set
	assign sclk_is_input  = clock_enable_high_in;
	assign sclk_is_output = ~clock_enable_high_in &
		(serial_sync_mode_in | clock_enable_low_in);
	// pin B1 only listens while receiving; B0 only drives while sending
	assign rxd_is_input   = receive_enable_in;
	assign txd_is_output  = transmit_enable_in;

	always_comb begin
		b_alt_drive = 3'b000;
		b_alt_input = 3'b000;
		b_alt_val   = {serial_clock_in, 1'b0, serial_txd_in};
		if (serial_live) begin
			b_alt_input[2] = sclk_is_input;
			b_alt_drive[2] = sclk_is_output;
			b_alt_input[1] = rxd_is_input;
			b_alt_drive[0] = txd_is_output;
		end
	end

	assign serial_clock_out = gated_pin(b_alt_input[2], port_b_pin_in[2]);
	assign serial_rxd_out   = gated_pin(b_alt_input[1], port_b_pin_in[1]);

	//------------------------------------------------------------
	// per-pin muxes
	//------------------------------------------------------------
	logic [7:0] port_a_rd_raw;

	for (genvar i = 0; i < 8; i++) begin : g_port_a
		port_bit_mux u_bit (
			.dir_in       (port_a_dir_ff[i]),
			.latch_in     (port_a_latch_ff[i]),
			.pin_in       (port_a_pin_in[i]),
			.alt_drive_in (a_alt_drive[i]),
			.alt_input_in (a_alt_input[i]),
			.alt_val_in   (a_alt_val[i]),
			.pin_out      (port_a_pin_out[i]),
			.pin_oe_out   (port_a_pin_oe_out[i]),
			.rd_out       (port_a_rd_raw[i])
		);
	end

	// bit 6 reads the pin even with direction 1, so its latch bit stays unseen
	always_comb begin
		port_a_rd = port_a_rd_raw;
		port_a_rd[clock_pin_bit] = port_a_pin_in[clock_pin_bit];
	end

	for (genvar j = 0; j < 3; j++) begin : g_port_b
		port_bit_mux u_bit (
			.dir_in       (port_b_dir_ff[j]),
			.latch_in     (port_b_latch_ff[j]),
			.pin_in       (port_b_pin_in[j]),
			.alt_drive_in (b_alt_drive[j]),
			.alt_input_in (b_alt_input[j]),
			.alt_val_in   (b_alt_val[j]),
			.pin_out      (port_b_pin_out[j]),
			.pin_oe_out   (port_b_pin_oe_out[j]),
			.rd_out       (port_b_rd[j])
		);
	end

endmodule

// ---- port_mux_pkg.sv ----
// package: register map, reset values and mode codes for the two-port pin mux
// assumes: byte-wide registers, one per aligned 32-bit Avalon word
package port_mux_pkg;

	typedef enum logic [1:0] {
		mode_rsvd,
		mode_exp_rom_off,
		mode_exp_rom_on,
		mode_single_chip
	} op_mode_t;

	// printed offsets are not all multiples of four: index * 4 is the byte address
	localparam logic [15:0] port_a_direction_idx  = 16'hFFB5;
	localparam logic [15:0] port_a_data_latch_idx = 16'hFFB7;
	localparam logic [15:0] port_b_direction_idx  = 16'hFFB8;
	localparam logic [15:0] port_b_data_latch_idx = 16'hFFBA;

	localparam logic [7:0] port_a_dir_rst_expanded = 8'h40;
	localparam logic [7:0] port_a_dir_rst_single   = 8'h00;
	localparam logic [7:0] port_a_data_rst         = 8'h00;
	localparam logic [7:0] port_b_dir_rst          = 8'hF8;
	localparam logic [7:0] port_b_data_rst         = 8'hF8;
	localparam logic [7:0] wo_read_value           = 8'hFF;
	localparam logic [7:0] port_b_fixed_mask       = 8'hF8;

	localparam int clock_pin_bit  = 6;
	localparam int wait_pin_bit   = 7;
	localparam logic [1:0] wait_not_used = 2'b01;

endpackage

// ---- port_bit_mux.sv ----
// port_bit_mux: one pin's output mux, enable and read-back selection
// assumes: override controls are resolved by the caller
`timescale 1ns/1ps
module port_bit_mux (
	input  wire logic dir_in,
	input  wire logic latch_in,
	input  wire logic pin_in,
	input  wire logic alt_drive_in,
	input  wire logic alt_input_in,
	input  wire logic alt_val_in,
	output logic      pin_out,
	output logic      pin_oe_out,
	output logic      rd_out
);
	// alternate output wins; alternate input forces release
	assign pin_out    = alt_drive_in ? alt_val_in : latch_in;
	assign pin_oe_out = alt_drive_in | (~alt_input_in & dir_in);
	// read-back follows direction even for alternate-function pins
	assign rd_out     = dir_in ? latch_in : pin_in;
endmodule

// ---- port_pin_board.sv ----
// board model: resolves each pin from the device drive and the board level
// assumes: board drivers give way wherever the device enables its output
`timescale 1ns/1ps
module port_pin_board (
	input  wire logic [7:0] a_ext_in,
	input  wire logic [7:0] a_out_in,
	input  wire logic [7:0] a_oe_in,
	input  wire logic [2:0] b_ext_in,
	input  wire logic [2:0] b_out_in,
	input  wire logic [2:0] b_oe_in,
	output logic      [7:0] a_pin_out,
	output logic      [2:0] b_pin_out
);
	// no contention modelled: a driving device always wins
	assign a_pin_out = (a_oe_in & a_out_in) | (~a_oe_in & a_ext_in);
	assign b_pin_out = (b_oe_in & b_out_in) | (~b_oe_in & b_ext_in);
endmodule

// ---- dual_port_pin_mux_io_asserts.sv ----
// checker: bus timing and pin-mux relations of the two-port pin mux
// assumes: bound to the top module, single clock domain
`timescale 1ns/1ps
module dual_port_pin_mux_io_asserts (
	input wire logic       clk_in,
	input wire logic       rst_in,
	input wire logic       hw_standby_in,
	input wire logic       sw_standby_in,
	input wire logic [1:0] op_mode_in,
	input wire logic       avs_read_in,
	input wire logic       avs_write_in,
	input wire logic       avs_waitrequest_out,
	input wire logic [7:0] port_a_pin_in,
	input wire logic [7:0] port_a_pin_out,
	input wire logic [7:0] port_a_pin_oe_out,
	input wire logic [2:0] port_b_pin_out,
	input wire logic [2:0] port_b_pin_oe_out,
	input wire logic       sys_clock_in,
	input wire logic       address_strobe_n_in,
	input wire logic       write_strobe_n_in,
	input wire logic       read_strobe_n_in,
	input wire logic       ext_irq0_enable_in,
	input wire logic       adc_trigger_enable_in,
	input wire logic [2:0] ext_irq_n_out,
	input wire logic       adc_external_trigger_n_out,
	input wire logic       transmit_enable_in,
	input wire logic       serial_txd_in,
	input wire logic       clock_enable_high_in,
	input wire logic       serial_reset_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (rst_in);
	logic expanded;
	assign expanded = (op_mode_in == 2'h1 || op_mode_in == 2'h2) && !hw_standby_in;
	a_read_one_wait: assert property ($rose(avs_read_in) |-> avs_waitrequest_out ##1 !avs_waitrequest_out)
		else $error("read wait not one cycle");
	a_write_no_wait: assert property (avs_write_in |-> !avs_waitrequest_out)
		else $error("write stalled");
	a_clock_pin_out: assert property (expanded |-> port_a_pin_oe_out[6] && port_a_pin_out[6] == sys_clock_in)
		else $error("clock pin not driven");
	a_strobe_pins: assert property (expanded |-> port_a_pin_oe_out[5:3] == 3'h7 && port_a_pin_out[5:3] == {address_strobe_n_in, write_strobe_n_in, read_strobe_n_in})
		else $error("strobe pins wrong");
	a_irq_feed: assert property (ext_irq0_enable_in |-> ext_irq_n_out[0] == port_a_pin_in[2])
		else $error("irq0 not fed");
	a_adc_feed: assert property (adc_trigger_enable_in |-> adc_external_trigger_n_out == port_a_pin_in[0])
		else $error("adc trigger not fed");
	a_txd_pin: assert property (transmit_enable_in && !sw_standby_in && !hw_standby_in |-> port_b_pin_oe_out[0] && port_b_pin_out[0] == serial_txd_in)
		else $error("txd pin wrong");
	a_serial_reset_held: assert property (sw_standby_in |-> serial_reset_out)
		else $error("serial not reset");
	a_sclk_input: assert property (clock_enable_high_in && !sw_standby_in && !hw_standby_in |-> !port_b_pin_oe_out[2])
		else $error("clock pin driven");
	cover property ($rose(avs_read_in));
	cover property (sw_standby_in && transmit_enable_in);
	cover property (expanded && !avs_write_in);
endmodule
bind dual_port_pin_mux_io dual_port_pin_mux_io_asserts i_dual_port_pin_mux_io_asserts (.*);

// ---- test_dual_port_pin_mux_io.sv ----
// testbench: register, pin-mux and standby scenarios for the two-port pin mux
// assumes: board model resolves pins, bench plays cpu bus and peripherals
`timescale 1ns/1ps
module test_dual_port_pin_mux_io;
	import port_mux_pkg::*;
	logic clk_in = 1'b0, rst_in = 1'b1, hw_standby_in = 1'b0, sw_standby_in = 1'b0;
	logic [1:0] op_mode_in = 2'h3, avs_response_out;
	logic [17:0] avs_address_in = 18'h0;
	logic avs_read_in = 1'b0, avs_write_in = 1'b0, avs_waitrequest_out;
	logic [31:0] avs_writedata_in = 32'h0, avs_readdata_out;
	logic [3:0] avs_byteenable_in = 4'hF;
	logic [7:0] port_a_pin_in, port_a_pin_out, port_a_pin_oe_out, a_ext = 8'hA5;
	logic [2:0] port_b_pin_in, port_b_pin_out, port_b_pin_oe_out, ext_irq_n_out, b_ext = 3'h5;
	logic sys_clock_in = 1'b0, address_strobe_n_in = 1'b1, write_strobe_n_in = 1'b0;
	logic read_strobe_n_in = 1'b1, wait_select_high_in = 1'b0, wait_select_low_in = 1'b0;
	logic ext_irq0_enable_in = 1'b0, ext_irq1_enable_in = 1'b0, ext_irq2_enable_in = 1'b0;
	logic adc_trigger_enable_in = 1'b0, serial_sync_mode_in = 1'b0, clock_enable_low_in = 1'b0;
	logic clock_enable_high_in = 1'b0, receive_enable_in = 1'b0, transmit_enable_in = 1'b0;
	logic serial_clock_in = 1'b0, serial_txd_in = 1'b1, serial_clock_out, serial_rxd_out;
	logic bus_wait_n_out, adc_external_trigger_n_out, serial_reset_out;
	int failures = 0, cmp_count = 0, cycles = 0;
	localparam logic [17:0] ad_a = {port_a_direction_idx, 2'b00};
	localparam logic [17:0] dt_a = {port_a_data_latch_idx, 2'b00};
	localparam logic [17:0] ad_b = {port_b_direction_idx, 2'b00};
	localparam logic [17:0] dt_b = {port_b_data_latch_idx, 2'b00};
	dual_port_pin_mux_io i_dual_port_pin_mux_io (.*);
	port_pin_board i_port_pin_board (.a_ext_in(a_ext), .a_out_in(port_a_pin_out),
		.a_oe_in(port_a_pin_oe_out), .b_ext_in(b_ext), .b_out_in(port_b_pin_out),
		.b_oe_in(port_b_pin_oe_out), .a_pin_out(port_a_pin_in), .b_pin_out(port_b_pin_in));
	initial forever #12.5 clk_in = ~clk_in;
	// ----------------------------------------
	// bus tasks and comparison
	// ----------------------------------------
	task stop_test();
		if (failures == 0 && cmp_count > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			failures++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task bus_wr(input logic [17:0] a, input logic [7:0] d);
		@(posedge clk_in);
		avs_address_in <= a;
		avs_writedata_in <= {24'h0, d};
		avs_write_in <= 1'b1;
		do @(posedge clk_in); while (avs_waitrequest_out !== 1'b0);
		avs_write_in <= 1'b0;
	endtask
	task rd_chk(input logic [17:0] a, input logic [7:0] exp);
		@(posedge clk_in);
		avs_address_in <= a;
		avs_read_in <= 1'b1;
		do @(posedge clk_in); while (avs_waitrequest_out !== 1'b0);
		chk(avs_readdata_out, {24'h0, exp});
		chk({30'h0, avs_response_out}, 32'h0);
		avs_read_in <= 1'b0;
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task t_defaults();
		rd_chk(ad_a, 8'hFF);
		rd_chk(ad_b, 8'hFF);
		rd_chk(18'h3FED8, 8'h00);
		rd_chk(dt_a, a_ext);
		rd_chk(dt_b, 8'hF8 | b_ext);
		chk(port_a_pin_oe_out, 8'h00);
		chk(port_b_pin_oe_out, 3'h0);
	endtask
	task t_port_a();
		bus_wr(ad_a, 8'h0F);
		bus_wr(dt_a, 8'h5A);
		@(negedge clk_in);
		chk({port_a_pin_oe_out, port_a_pin_out[3:0]}, 12'h0FA);
		rd_chk(dt_a, 8'hAA);
		chk({adc_external_trigger_n_out, ext_irq_n_out}, 4'hF);
		@(posedge clk_in);
		{adc_trigger_enable_in, ext_irq2_enable_in, ext_irq1_enable_in, ext_irq0_enable_in} <= 4'hF;
		@(negedge clk_in);
		chk({adc_external_trigger_n_out, ext_irq_n_out}, 4'h2);
		bus_wr(ad_a, 8'h4F);
		@(negedge clk_in);
		chk({port_a_pin_oe_out[6], port_a_pin_out[6]}, 2'b10);
		rd_chk(dt_a, 8'hAA);
	endtask
	task t_standby();
		bus_wr(ad_b, 8'h07);
		bus_wr(dt_b, 8'hFD);
		@(posedge clk_in);
		{transmit_enable_in, receive_enable_in, clock_enable_low_in} <= 3'h7;
		@(negedge clk_in);
		chk({port_b_pin_oe_out, port_b_pin_out[2], port_b_pin_out[0]}, 5'h15);
		chk(serial_rxd_out, b_ext[1]);
		rd_chk(dt_b, 8'hFD);
		@(posedge clk_in);
		clock_enable_high_in <= 1'b1;
		@(negedge clk_in);
		chk({port_b_pin_oe_out[2], serial_clock_out}, {1'b0, b_ext[2]});
		@(posedge clk_in);
		sw_standby_in <= 1'b1;
		@(negedge clk_in);
		chk({port_b_pin_oe_out, port_b_pin_out, serial_reset_out}, 7'h7B);
		chk({port_a_pin_oe_out, port_a_pin_out[3:0]}, 12'h4FA);
		@(posedge clk_in);
		sw_standby_in <= 1'b0;
		bus_wr(dt_b, 8'h02);
		rd_chk(dt_b, 8'hFA);
	endtask
	task t_expanded();
		@(posedge clk_in);
		op_mode_in <= 2'h1;
		hw_standby_in <= 1'b1;
		@(posedge clk_in);
		hw_standby_in <= 1'b0;
		rd_chk(dt_b, 8'hFD);
		bus_wr(ad_a, 8'h38);
		@(negedge clk_in);
		chk({port_a_pin_oe_out, port_a_pin_out[5:3]}, 11'h3C5);
		chk(bus_wait_n_out, a_ext[7]);
		rd_chk(dt_a, 8'h85);
		@(posedge clk_in);
		wait_select_low_in <= 1'b1;
		bus_wr(ad_a, 8'hB8);
		@(negedge clk_in);
		chk({port_a_pin_oe_out[7], bus_wait_n_out}, 2'b11);
	endtask
	always @(posedge clk_in) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			failures++;
			stop_test();
		end
	end
	initial begin
		repeat (10) @(posedge clk_in);
		rst_in <= 1'b0;
		t_defaults();
		t_port_a();
		t_standby();
		t_expanded();
		stop_test();
	end
endmodule
